// *** include/scie_defs.svh ***
// Constants for the system-control instruction executor.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
// How it works
// - Subroutine exit: stack pointer minus 2, then pc loads from that stack word.
// - Interrupt exit returns like subroutine exit and re-enables global interrupt.
// - Computed jump: next pc is pc plus unsigned working register.
// - Interrupt on sets global enable, letting pending requests reach processing unit.
// - Interrupt off clears global enable, blocking all requests.
// - Full halt stops system clock and oscillators.
// - Core halt gates system clock, oscillators keep running.
// - Software reset resets whole chip like hardware reset.
// - Watchdog kick clears watchdog count.
// - Jump, call, indirect move, computed jump, both exits take two cycles.
// - Skip instructions take two cycles when skipping, else one; others one.
// - System-control instructions leave zero, carry, half-carry, wrap flags unchanged.
// - Call stores pc plus 1 at stack, loads target, stack pointer plus 2.
`ifndef SCIE_DEFS_SVH
`define SCIE_DEFS_SVH
`define SCIE_SP_STEP 8'h02
`define SCIE_PC_STEP 1
`define SCIE_GIE_RST 1'b0
`define SCIE_RST_PULSE_CYC 2
`endif

// *** include/scie_pkg.sv ***
// Types for the system-control instruction executor.
// Assumes the decoder upstream classifies each instruction.
package scie_pkg;
	typedef enum logic [3:0] {
		SCIE_OP_OTHER,
		SCIE_OP_IDLE,
		SCIE_OP_JUMP,
		SCIE_OP_CALL,
		SCIE_OP_IDXM,
		SCIE_OP_PCADD,
		SCIE_OP_RET,
		SCIE_OP_RETI,
		SCIE_OP_GIE_ON,
		SCIE_OP_GIE_OFF,
		SCIE_OP_STOPALL,
		SCIE_OP_STOPCPU,
		SCIE_OP_SWRST,
		SCIE_OP_WDKICK,
		SCIE_OP_SKIPTEST
	} scie_op_t;
	typedef struct packed {
		scie_op_t op;
		logic [15:0] target;
		logic skip_true;
	} scie_instr_t;
	typedef struct packed {
		logic zero;
		logic carry;
		logic half_carry_flag;
		logic signed_wrap_flag;
	} scie_flags_t;
endpackage

// *** design/scie_exec.sv ***
// System-control instruction execution: pc, stack pointer, global enable, halts, resets.
// Assumes one instruction offered per idle cycle with instr_valid; stack memory answers combinationally.
`timescale 1ns/100ps
`include "scie_defs.svh"
module scie_exec #(
	parameter int PC_W = 12,
	parameter int SP_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire scie_pkg::scie_instr_t instr,
	input wire logic [7:0] working_register,
	input wire logic irq_pending,
	input wire logic [PC_W-1:0] irq_vector,
	input wire logic [PC_W-1:0] stack_rdata,
	input wire scie_pkg::scie_flags_t flags_in,
	output logic instr_ready,
	output logic [PC_W-1:0] pc,
	output logic [SP_W-1:0] sp,
	output logic stack_we,
	output logic [SP_W-1:0] stack_addr,
	output logic [PC_W-1:0] stack_wdata,
	output logic global_int_en,
	output logic irq_to_unit,
	output logic irq_taken,
	output logic sys_clk_en,
	output logic osc_en,
	output logic chip_reset,
	output logic wdt_clear,
	output scie_pkg::scie_flags_t flags_out
);
	// Target field is 16 bits, offset 8 bits, stack step 2
	if (PC_W < 8 || PC_W > 16 || SP_W < 2)
	begin
		$error("scie_exec: unsupported width");
	end

	typedef enum logic [1:0] {SCIE_ST_RUN, SCIE_ST_SECOND, SCIE_ST_HALT} scie_state_t;

	scie_state_t state_r, state_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt, pend_pc_r, pend_pc_nxt;
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic gie_r, gie_nxt, gie_set_r, gie_set_nxt;
	logic ret_r, ret_nxt;
	logic stop_all_r, stop_all_nxt;
	logic [1:0] rst_cnt_r, rst_cnt_nxt;
	logic we_nxt, we_r, wdt_nxt, wdt_r;
	logic [SP_W-1:0] addr_nxt, addr_r;
	logic [PC_W-1:0] wdata_nxt, wdata_r;
	logic take_irq;

	assign take_irq = (state_r == SCIE_ST_RUN) && gie_r && irq_pending && rst_cnt_r == 2'h0;
	assign instr_ready = (state_r == SCIE_ST_RUN) && !take_irq && rst_cnt_r == 2'h0;

	always_comb
	begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		pend_pc_nxt = pend_pc_r;
		sp_nxt = sp_r;
		gie_nxt = gie_r;
		gie_set_nxt = 1'b0;
		ret_nxt = 1'b0;
		stop_all_nxt = stop_all_r;
		rst_cnt_nxt = (rst_cnt_r != 2'h0) ? rst_cnt_r - 2'h1 : 2'h0;
		we_nxt = 1'b0;
		wdt_nxt = 1'b0;
		addr_nxt = sp_r;
		wdata_nxt = '0;
		case (state_r)
			SCIE_ST_RUN:
			begin
				if (take_irq)
				begin
					gie_nxt = 1'b0;
					we_nxt = 1'b1;
					wdata_nxt = pc_r;
					sp_nxt = sp_r + SP_W'(`SCIE_SP_STEP);
					pend_pc_nxt = irq_vector;
					state_nxt = SCIE_ST_SECOND;
				end
				else if (instr_valid && instr_ready)
				begin
					pc_nxt = pc_r + PC_W'(`SCIE_PC_STEP);
					case (instr.op)
						scie_pkg::SCIE_OP_JUMP, scie_pkg::SCIE_OP_IDXM:
						begin
							pend_pc_nxt = (instr.op == scie_pkg::SCIE_OP_JUMP) ? instr.target[PC_W-1:0] : pc_nxt;
							state_nxt = SCIE_ST_SECOND;
						end
						scie_pkg::SCIE_OP_CALL:
						begin
							we_nxt = 1'b1;
							wdata_nxt = pc_r + PC_W'(`SCIE_PC_STEP);
							pend_pc_nxt = instr.target[PC_W-1:0];
							sp_nxt = sp_r + SP_W'(`SCIE_SP_STEP);
							state_nxt = SCIE_ST_SECOND;
						end
						scie_pkg::SCIE_OP_PCADD:
						begin
							pend_pc_nxt = pc_r + PC_W'(working_register);
							state_nxt = SCIE_ST_SECOND;
						end
						scie_pkg::SCIE_OP_RET, scie_pkg::SCIE_OP_RETI:
						begin
							sp_nxt = sp_r - SP_W'(`SCIE_SP_STEP);
							addr_nxt = sp_r - SP_W'(`SCIE_SP_STEP);
							gie_set_nxt = (instr.op == scie_pkg::SCIE_OP_RETI);
							ret_nxt = 1'b1;
							state_nxt = SCIE_ST_SECOND;
						end
						scie_pkg::SCIE_OP_GIE_ON: gie_nxt = 1'b1;
						scie_pkg::SCIE_OP_GIE_OFF: gie_nxt = 1'b0;
						scie_pkg::SCIE_OP_STOPALL:
						begin
							stop_all_nxt = 1'b1;
							state_nxt = SCIE_ST_HALT;
						end
						scie_pkg::SCIE_OP_STOPCPU: state_nxt = SCIE_ST_HALT;
						scie_pkg::SCIE_OP_SWRST: rst_cnt_nxt = 2'(`SCIE_RST_PULSE_CYC);
						scie_pkg::SCIE_OP_WDKICK: wdt_nxt = 1'b1;
						scie_pkg::SCIE_OP_SKIPTEST:
						begin
							if (instr.skip_true)
							begin
								pend_pc_nxt = pc_r + PC_W'(2);
								state_nxt = SCIE_ST_SECOND;
							end
						end
						default: ;
					endcase
				end
			end
			SCIE_ST_SECOND:
			begin
				if (ret_r)
					pc_nxt = stack_rdata;
				else
					pc_nxt = pend_pc_r;
				if (gie_set_r)
					gie_nxt = 1'b1;
				state_nxt = SCIE_ST_RUN;
			end
			SCIE_ST_HALT:
			begin
				if (irq_pending)
				begin
					stop_all_nxt = 1'b0;
					state_nxt = SCIE_ST_RUN;
				end
			end
			default: state_nxt = SCIE_ST_RUN;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst || chip_reset)
		begin
			state_r <= SCIE_ST_RUN;
			pc_r <= '0;
			pend_pc_r <= '0;
			sp_r <= '0;
			gie_r <= `SCIE_GIE_RST;
			gie_set_r <= 1'b0;
			ret_r <= 1'b0;
			stop_all_r <= 1'b0;
			we_r <= 1'b0;
			wdt_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			pend_pc_r <= pend_pc_nxt;
			sp_r <= sp_nxt;
			gie_r <= gie_nxt;
			gie_set_r <= gie_set_nxt;
			ret_r <= ret_nxt;
			stop_all_r <= stop_all_nxt;
			we_r <= we_nxt;
			wdt_r <= wdt_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			rst_cnt_r <= 2'h0;
		else
			rst_cnt_r <= rst_cnt_nxt;
	end

	assign chip_reset = rst_cnt_r != 2'h0;
	assign pc = pc_r;
	assign sp = sp_r;
	assign stack_we = we_r;
	assign stack_addr = addr_r;
	assign stack_wdata = wdata_r;
	assign global_int_en = gie_r;
	assign irq_to_unit = gie_r && irq_pending;
	assign irq_taken = take_irq;
	assign sys_clk_en = state_r != SCIE_ST_HALT;
	assign osc_en = !stop_all_r;
	assign wdt_clear = wdt_r;
	assign flags_out = flags_in;

	// Checks
	sp_ret_a: assert property (@(posedge clk) disable iff (srst)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_RET && !chip_reset
		|=> sp == $past(sp) - SP_W'(2)) else $error("ret sp step wrong");
	reti_gie_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_RETI |=> ##1 global_int_en)
		else $error("reti did not enable");
	two_cycle_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_JUMP
		|=> !instr_ready ##1 pc == $past(instr.target[PC_W-1:0], 2))
		else $error("jump timing wrong");
	gie_off_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_GIE_OFF |=> !irq_to_unit)
		else $error("irq not blocked");
	irq_clr_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		irq_taken |=> !global_int_en) else $error("gie kept on irq");
	call_sp_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_CALL
		|=> stack_we && sp == $past(sp) + SP_W'(2) && stack_wdata == $past(pc) + PC_W'(1))
		else $error("call push wrong");
	halt_clk_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_STOPCPU |=> !sys_clk_en && osc_en)
		else $error("core halt wrong");
	swrst_a: assert property (@(posedge clk) disable iff (srst)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_SWRST && !chip_reset |=> chip_reset [*2])
		else $error("soft reset missing");
	idle_pc_a: assert property (@(posedge clk) disable iff (srst || chip_reset)
		instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_IDLE
		|=> pc == $past(pc) + PC_W'(1) && sp == $past(sp) && !stack_we
		&& global_int_en == $past(global_int_en) && (instr_ready || irq_taken))
		else $error("idle pc wrong");
	call_c: cover property (@(posedge clk) instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_CALL);
	ret_c: cover property (@(posedge clk) instr_valid && instr_ready && instr.op == scie_pkg::SCIE_OP_RETI);
	irq_c: cover property (@(posedge clk) irq_taken);
	halt_c: cover property (@(posedge clk) !sys_clk_en);
endmodule

// *** verif/scie_stack_model.sv ***
// Stack word memory on the executor's stack port.
// Assumes writes on stack_we at the clock edge, reads answered at once.
`timescale 1ns/100ps
module scie_stack_model #(
	parameter int PC_W = 12,
	parameter int SP_W = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [SP_W-1:0] addr,
	input wire logic [PC_W-1:0] wdata,
	output logic [PC_W-1:0] rdata
);
	logic [PC_W-1:0] mem_r [0:(1<<SP_W)-1];
	always_ff @(posedge clk)
	begin
		if (we)
			mem_r[addr] <= wdata;
	end
	assign rdata = mem_r[addr];
endmodule

// *** verif/system_control_instruction_exec_tb.sv ***
// Self-checking bench for the system-control executor.
// Assumes scie_exec with default widths and the stack model beside it.
`timescale 1ns/100ps
module system_control_instruction_exec_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic instr_valid = 1'b0;
	scie_pkg::scie_instr_t instr = '0;
	logic [7:0] wreg = 8'h00;
	logic irq_pending = 1'b0;
	logic [11:0] irq_vector = 12'h000;
	scie_pkg::scie_flags_t flags_in = '0;
	scie_pkg::scie_flags_t flags_out;
	logic instr_ready, stack_we, global_int_en, irq_to_unit, irq_taken, sys_clk_en, osc_en, chip_reset, wdt_clear;
	logic [11:0] pc, stack_wdata, stack_rdata;
	logic [7:0] sp, stack_addr;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	int wdt_n = 0;
	int rst_n = 0;
	logic wait_res = 1'b0;
	logic [15:0] exp_q [$];
	logic [11:0] vec;
	always #10 clk = ~clk;
	scie_exec dut_u (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .working_register(wreg),
		.irq_pending(irq_pending), .irq_vector(irq_vector), .stack_rdata(stack_rdata), .flags_in(flags_in),
		.instr_ready(instr_ready), .pc(pc), .sp(sp), .stack_we(stack_we), .stack_addr(stack_addr),
		.stack_wdata(stack_wdata), .global_int_en(global_int_en), .irq_to_unit(irq_to_unit),
		.irq_taken(irq_taken), .sys_clk_en(sys_clk_en), .osc_en(osc_en), .chip_reset(chip_reset),
		.wdt_clear(wdt_clear), .flags_out(flags_out));
	scie_stack_model #(.PC_W(12), .SP_W(8)) stk_u (.clk(clk), .we(stack_we), .addr(stack_addr),
		.wdata(stack_wdata), .rdata(stack_rdata));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic offer(input scie_pkg::scie_op_t op, input logic [15:0] tgt, input logic sk);
		int n;
		n = 0;
		@(negedge clk);
		while (instr_ready !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (instr_ready !== 1'b1)
			mismatches++;
		instr_valid = 1'b1;
		wait_res = exp_q.size() > 0;
		instr = '{op, tgt, sk};
		flags_in = scie_pkg::scie_flags_t'(4'($urandom));
		@(negedge clk);
		instr_valid = 1'b0;
	endtask
	// Offer one op, note cycle count and final pc, wait for the result
	task automatic issue(input scie_pkg::scie_op_t op, input logic [15:0] tgt, input logic sk, input logic [15:0] exp);
		int n;
		n = 0;
		exp_q.push_back(exp);
		offer(op, tgt, sk);
		while (wait_res && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (wait_res)
		begin
			mismatches++;
			wait_res = 1'b0;
			exp_q.delete();
		end
	endtask
	always @(posedge clk)
	begin
		#1;
		cmp(16'(flags_out), 16'(flags_in));
		wdt_n = wdt_n + int'(wdt_clear);
		rst_n = rst_n + int'(chip_reset);
		if (wait_res)
		begin
			cyc++;
			if (instr_ready === 1'b1)
			begin
				cmp({4'(cyc), pc}, exp_q.pop_front());
				wait_res = 1'b0;
				cyc = 0;
			end
		end
	end
	initial
	begin
		#60000;
		mismatches++;
		summarize();
	end
	initial
	begin
		void'($urandom(7));
		repeat (12) @(negedge clk);
		srst = 1'b0;
		vec = 12'($urandom);
		irq_vector = vec;
		#1;
		cmp({global_int_en, osc_en, sys_clk_en, chip_reset, pc}, 16'h6000);
		issue(scie_pkg::SCIE_OP_IDLE, 16'h0000, 1'b0, 16'h1001);
		issue(scie_pkg::SCIE_OP_JUMP, 16'h0100, 1'b0, 16'h2100);
		issue(scie_pkg::SCIE_OP_SKIPTEST, 16'h0000, 1'b1, 16'h2102);
		issue(scie_pkg::SCIE_OP_SKIPTEST, 16'h0000, 1'b0, 16'h1103);
		issue(scie_pkg::SCIE_OP_OTHER, 16'h0000, 1'b0, 16'h1104);
		issue(scie_pkg::SCIE_OP_CALL, 16'h0200, 1'b0, 16'h2200);
		cmp(16'(sp), 16'h0002);
		issue(scie_pkg::SCIE_OP_IDXM, 16'h0000, 1'b0, 16'h2201);
		wreg = 8'($urandom_range(1, 255));
		issue(scie_pkg::SCIE_OP_PCADD, 16'h0000, 1'b0, {4'h2, 12'h201 + 12'(wreg)});
		issue(scie_pkg::SCIE_OP_RET, 16'h0000, 1'b0, 16'h2105);
		cmp(16'(sp), 16'h0000);
		issue(scie_pkg::SCIE_OP_GIE_ON, 16'h0000, 1'b0, 16'h1106);
		irq_pending = 1'b1;
		#1;
		cmp({14'h0, irq_to_unit, irq_taken}, 16'h0003);
		repeat (2) @(posedge clk);
		#2;
		cmp({3'h0, global_int_en, pc}, {4'h0, vec});
		@(negedge clk);
		irq_pending = 1'b0;
		issue(scie_pkg::SCIE_OP_RETI, 16'h0000, 1'b0, 16'h2106);
		cmp({15'h0, global_int_en}, 16'h0001);
		issue(scie_pkg::SCIE_OP_GIE_OFF, 16'h0000, 1'b0, 16'h1107);
		irq_pending = 1'b1;
		repeat (3) @(negedge clk);
		cmp({3'h0, irq_to_unit, pc}, 16'h0107);
		irq_pending = 1'b0;
		issue(scie_pkg::SCIE_OP_WDKICK, 16'h0000, 1'b0, 16'h1108);
		cmp(16'(wdt_n), 16'h0001);
		for (int k = 0; k < 2; k++)
		begin
			offer(k == 0 ? scie_pkg::SCIE_OP_STOPCPU : scie_pkg::SCIE_OP_STOPALL, 16'h0000, 1'b0);
			repeat (3) @(negedge clk);
			cmp({sys_clk_en, osc_en, instr_ready}, k == 0 ? 16'h0002 : 16'h0000);
			irq_pending = 1'b1;
			@(negedge clk);
			irq_pending = 1'b0;
			repeat (3) @(negedge clk);
			cmp({osc_en, sys_clk_en}, 16'h0003);
		end
		issue(scie_pkg::SCIE_OP_CALL, 16'h0300, 1'b0, 16'h2300);
		issue(scie_pkg::SCIE_OP_GIE_ON, 16'h0000, 1'b0, 16'h1301);
		offer(scie_pkg::SCIE_OP_SWRST, 16'h0000, 1'b0);
		repeat (6) @(negedge clk);
		cmp({global_int_en, 3'(rst_n), pc}, 16'h2000);
		cmp(16'(sp), 16'h0000);
		summarize();
	end
endmodule
